// [decode_pkg.sv]
package decode_pkg;

  // Prefix and escape byte values
  localparam logic [7:0] PFX_OP_SIZE   = 8'h66;
  localparam logic [7:0] PFX_ADDR_SIZE = 8'h67;
  localparam logic [7:0] ESC_TWO_BYTE  = 8'h0f;

  // Addressing forms
  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8   = 2'h1;
  localparam logic [1:0] MOD_DISPW   = 2'h2;
  localparam logic [1:0] MOD_REG     = 2'h3;

  // Special selector codes
  localparam logic [2:0] RM_SIB      = 3'h4;
  localparam logic [2:0] RM16_DIRECT = 3'h6;
  localparam logic [2:0] RM32_DIRECT = 3'h5;
  localparam logic [2:0] BASE_DIRECT = 3'h5;
  localparam logic [2:0] INDEX_NONE  = 3'h4;

  // General register numbers used by the address tables
  localparam logic [2:0] REG_SP = 3'h4;
  localparam logic [2:0] REG_BX = 3'h3;
  localparam logic [2:0] REG_BP = 3'h5;
  localparam logic [2:0] REG_SI = 3'h6;
  localparam logic [2:0] REG_DI = 3'h7;

  // Field lengths in bytes
  localparam logic [2:0] LEN_NONE  = 3'h0;
  localparam logic [2:0] LEN_BYTE  = 3'h1;
  localparam logic [2:0] LEN_WORD  = 3'h2;
  localparam logic [2:0] LEN_DWORD = 3'h4;

  // Bit positions inside an opcode byte
  localparam int W_BIT   = 0;
  localparam int D_BIT   = 1;
  localparam int S_BIT   = 1;
  localparam int SEG_LSB = 3;

  // Reset values and sizes
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam int         BUF_DEPTH = 2;

  // Immediate kind supplied with the last opcode byte
  typedef enum logic [1:0] {IMM_NONE, IMM_BYTE, IMM_VAR, IMM_FULL} imm_kind_type;

  // Decoder states
  typedef enum logic [2:0] {
    ST_OPCODE, ST_OPCODE2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM, ST_EMIT
  } dec_state_type;

  // One decoded instruction front
  typedef struct packed {
    logic        op32;
    logic        addr32;
    logic        two_byte;
    logic [7:0]  opcode;
    logic        byte_or_full_flag;
    logic        flow_way_bit;
    logic        imm_extend_flag;
    logic [2:0]  op_reg;
    logic [3:0]  condition_code;
    logic [1:0]  segment_pick_short;
    logic [2:0]  segment_pick_long;
    logic        has_modrm;
    logic [1:0]  mod;
    logic [2:0]  operand_slot;
    logic [2:0]  rm;
    logic        reg_operand;
    logic        has_sib;
    logic [1:0]  multiplier_code;
    logic [2:0]  index_sel;
    logic [2:0]  base_sel;
    logic        base_valid;
    logic [2:0]  base_reg;
    logic        index_valid;
    logic [2:0]  index_reg;
    logic        stack_segment;
    logic        ea_undefined;
    logic [2:0]  disp_len;
    logic [31:0] disp;
    logic [2:0]  imm_len;
    logic [31:0] imm;
  } decode_rec_type;

endpackage

// [decode_link_if.sv]
`timescale 1ns/1ps
// Decoded record handed from the decoder core to the output buffer
interface decode_link_if;
  import decode_pkg::*;
  logic           valid;   // Record offered
  logic           ready;   // Buffer has room
  decode_rec_type data;    // Record contents

  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// [decode_out_buffer.sv]
`timescale 1ns/1ps
// Two-entry buffer so a stalled consumer never loses a record
module decode_out_buffer #(
  parameter int DEPTH = decode_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      sys_rst_in,
  // Filling side
  decode_link_if.dst                     fill,
  // Draining side
  output logic                           out_valid_out,
  output decode_pkg::decode_rec_type     out_data_out,
  input  wire logic                      out_ready_in
);
  import decode_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  decode_rec_type   mem_reg [DEPTH];  // Storage words
  logic [PTR_W-1:0] wr_ptr_reg;       // Next write slot
  logic [PTR_W-1:0] rd_ptr_reg;       // Oldest slot
  logic [PTR_W:0]   count_reg;        // Words held
  logic             push;             // Word enters
  logic             pop;              // Word leaves

  // Room while fewer than DEPTH words are held; an empty buffer must accept too
  assign fill.ready    = (count_reg < (PTR_W+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = fill.valid && fill.ready;
  assign pop           = out_valid_out && out_ready_in;

  // Storage written only on accepted words
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= fill.data;
    end
  end

  // Pointers wrap at the depth; depth is a power of two here
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= PTR_W'(wr_ptr_reg + 1'b1);
      if (pop)  rd_ptr_reg <= PTR_W'(rd_ptr_reg + 1'b1);
      count_reg <= (PTR_W+1)'(count_reg + push - pop);
    end
  end
endmodule

// [prefix_and_address_mode_decoder.sv]
`timescale 1ns/1ps
// Decodes prefixes, opcode, addressing bytes, displacement and immediate
module prefix_and_address_mode_decoder (
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       sys_rst_in,
  // Mode of the current code segment
  input  wire logic                       default_op32_in,
  input  wire logic                       default_addr32_in,
  input  wire logic                       compat_mode_in,
  // Instruction byte stream from the fetch unit
  input  wire logic [7:0]                 byte_in,
  input  wire logic                       byte_valid_in,
  input  wire logic                       has_modrm_in,
  input  decode_pkg::imm_kind_type        imm_kind_in,
  output logic                            byte_ready_out,
  // Decoded result toward execution and address generation
  output logic                            done_out,
  output decode_pkg::decode_rec_type      decode_out,
  input  wire logic                       done_ready_in
);
  import decode_pkg::*;

  // Address components of one memory operand
  typedef struct packed {
    logic       base_valid;
    logic [2:0] base_reg;
    logic       index_valid;
    logic [2:0] index_reg;
    logic       stack;
  } ea_type;

  dec_state_type  state_reg;     // Current field being collected
  dec_state_type  state_next;
  decode_rec_type rec_reg;       // Record under construction
  decode_rec_type rec_next;
  logic [1:0]     cnt_reg;       // Byte index inside disp or imm
  logic [1:0]     cnt_next;
  logic           opp_reg;       // Operand-size prefix seen
  logic           opp_next;
  logic           adp_reg;       // Address-size prefix seen
  logic           adp_next;

  decode_link_if link ();        // Path into the output buffer

  // 16-bit table: base from frame_word or base_word, index from pointers
  function automatic ea_type ea16_f(input logic [1:0] md, input logic [2:0] rm);
    ea_type e;
    e = '0;
    e.index_valid = (rm <= 3'h5);
    e.index_reg   = rm[0] ? REG_DI : REG_SI;
    e.base_valid  = (rm <= 3'h3) || (rm == 3'h7) ||
                    ((rm == RM16_DIRECT) && (md != MOD_NO_DISP));
    e.base_reg    = ((rm == 3'h2) || (rm == 3'h3) || (rm == 3'h6)) ? REG_BP : REG_BX;
    e.stack       = e.base_valid && (e.base_reg == REG_BP) &&
                    ((md == MOD_NO_DISP) || (md == MOD_DISP8));
    return e;
  endfunction

  // 32-bit table without sib: selector names the register directly
  function automatic ea_type ea32_f(input logic [1:0] md, input logic [2:0] rm);
    ea_type e;
    e = '0;
    e.base_valid = !((md == MOD_NO_DISP) && (rm == RM32_DIRECT));
    e.base_reg   = rm;
    e.stack      = (rm == REG_BP) && (md == MOD_DISP8);
    return e;
  endfunction

  // 32-bit with sib: base, scaled index, frame_register exclusion
  function automatic ea_type easib_f(input logic [1:0] md, input logic [7:0] sb);
    ea_type e;
    e = '0;
    e.base_valid  = !((sb[2:0] == BASE_DIRECT) && (md == MOD_NO_DISP));
    e.base_reg    = sb[2:0];
    e.index_valid = (sb[5:3] != INDEX_NONE);
    e.index_reg   = sb[5:3];
    e.stack       = (sb[2:0] == REG_SP) ||
                    ((sb[2:0] == REG_BP) && (md != MOD_NO_DISP));
    return e;
  endfunction

  // Effective widths: compat modes always default to 16 bits
  logic       op32_w;
  logic       addr32_w;
  assign op32_w   = (compat_mode_in ? 1'b0 : default_op32_in) ^ opp_reg;
  assign addr32_w = (compat_mode_in ? 1'b0 : default_addr32_in) ^ adp_reg;

  // Byte classification in the opcode state
  logic take;
  logic is_op_pfx;
  logic is_ad_pfx;
  logic is_escape;
  logic load_op;
  assign take      = byte_valid_in && byte_ready_out;
  assign is_op_pfx = (byte_in == PFX_OP_SIZE);
  assign is_ad_pfx = (byte_in == PFX_ADDR_SIZE);
  assign is_escape = (byte_in == ESC_TWO_BYTE) && !rec_reg.two_byte;
  assign load_op   = take && (((state_reg == ST_OPCODE) && !is_op_pfx &&
                     !is_ad_pfx && !is_escape) || (state_reg == ST_OPCODE2));

  // Immediate length: fixed byte, operand width, or byte/operand width by the w flag
  logic [2:0] imm_len_w;
  logic [2:0] full_len_w;
  assign full_len_w = op32_w ? LEN_DWORD : LEN_WORD;
  assign imm_len_w  = (imm_kind_in == IMM_BYTE) ? LEN_BYTE :
                      (imm_kind_in == IMM_FULL) ? full_len_w :
                      (imm_kind_in == IMM_VAR)  ?
                        (byte_in[W_BIT] ? full_len_w : LEN_BYTE) : LEN_NONE;

  // Addressing byte decode as seen on the stream
  logic [1:0] m_mod;
  logic [2:0] m_rm;
  logic       sib_w;
  logic [2:0] mdisp_w;
  ea_type     mea_w;
  assign m_mod = byte_in[7:6];
  assign m_rm  = byte_in[2:0];
  assign sib_w = rec_reg.addr32 && (m_rm == RM_SIB) && (m_mod != MOD_REG);
  assign mea_w = rec_reg.addr32 ? ea32_f(m_mod, m_rm) : ea16_f(m_mod, m_rm);
  assign mdisp_w =
    (m_mod == MOD_DISP8) ? LEN_BYTE :
    (m_mod == MOD_DISPW) ? (rec_reg.addr32 ? LEN_DWORD : LEN_WORD) :
    (m_mod == MOD_REG)   ? LEN_NONE :
    (rec_reg.addr32 ? ((m_rm == RM32_DIRECT) ? LEN_DWORD : LEN_NONE)
                    : ((m_rm == RM16_DIRECT) ? LEN_WORD : LEN_NONE));

  // Scale-index byte decode, form taken from the stored addressing byte
  logic [2:0] sdisp_w;
  ea_type     sea_w;
  assign sea_w   = easib_f(rec_reg.mod, byte_in);
  assign sdisp_w = ((rec_reg.mod == MOD_NO_DISP) && (byte_in[2:0] == BASE_DIRECT)) ?
                   LEN_DWORD : rec_reg.disp_len;

  // Where to go once displacement is complete
  dec_state_type imm_or_emit;
  logic          disp_last;
  logic          imm_last;
  assign imm_or_emit = (rec_reg.imm_len != LEN_NONE) ? ST_IMM : ST_EMIT;
  assign disp_last   = (3'({1'b0, cnt_reg} + 3'h1) == rec_reg.disp_len);
  assign imm_last    = (3'({1'b0, cnt_reg} + 3'h1) == rec_reg.imm_len);

  // No bytes are taken while a finished record waits for room
  assign byte_ready_out = (state_reg != ST_EMIT);
  assign link.valid     = (state_reg == ST_EMIT);
  assign link.data      = rec_reg;

  // Field sequencer
  always_comb begin
    rec_next   = rec_reg;
    state_next = state_reg;
    cnt_next   = cnt_reg;
    opp_next   = opp_reg;
    adp_next   = adp_reg;
    // Final opcode byte: widths frozen and embedded fields split
    if (load_op) begin
      rec_next.op32               = op32_w;
      rec_next.addr32             = addr32_w;
      rec_next.opcode             = byte_in;
      rec_next.byte_or_full_flag  = byte_in[W_BIT];
      rec_next.flow_way_bit       = byte_in[D_BIT];
      rec_next.imm_extend_flag    = byte_in[S_BIT];
      rec_next.op_reg             = byte_in[2:0];
      rec_next.condition_code     = byte_in[3:0];
      rec_next.segment_pick_short = byte_in[SEG_LSB +: 2];
      rec_next.segment_pick_long  = byte_in[SEG_LSB +: 3];
      rec_next.has_modrm          = has_modrm_in;
      rec_next.imm_len            = imm_len_w;
      if (has_modrm_in) begin
        state_next = ST_MODRM;
      end else if (imm_len_w != LEN_NONE) begin
        state_next = ST_IMM;
      end else begin
        state_next = ST_EMIT;
      end
    end
    case (state_reg)
      // Prefixes may repeat and come in any order before the opcode
      ST_OPCODE: begin
        if (take && is_op_pfx) begin
          opp_next = 1'b1;
        end else if (take && is_ad_pfx) begin
          adp_next = 1'b1;
        end else if (take && is_escape) begin
          rec_next.two_byte = 1'b1;
          state_next        = ST_OPCODE2;
        end
      end
      // Second opcode byte handled by the common load above
      ST_OPCODE2: begin
        state_next = load_op ? state_next : ST_OPCODE2;
      end
      // Addressing byte
      ST_MODRM: begin
        if (take) begin
          rec_next.mod          = m_mod;
          rec_next.operand_slot = byte_in[5:3];
          rec_next.rm           = m_rm;
          rec_next.reg_operand  = (m_mod == MOD_REG);
          rec_next.has_sib      = sib_w;
          rec_next.disp_len     = mdisp_w;
          if (m_mod != MOD_REG) begin
            rec_next.base_valid    = mea_w.base_valid;
            rec_next.base_reg      = mea_w.base_reg;
            rec_next.index_valid   = mea_w.index_valid;
            rec_next.index_reg     = mea_w.index_reg;
            rec_next.stack_segment = mea_w.stack;
          end
          if (sib_w) begin
            state_next = ST_SIB;
          end else if (mdisp_w != LEN_NONE) begin
            state_next = ST_DISP;
          end else begin
            state_next = imm_or_emit;
          end
        end
      end
      // Scale-index byte
      ST_SIB: begin
        if (take) begin
          rec_next.multiplier_code = byte_in[7:6];
          rec_next.index_sel       = byte_in[5:3];
          rec_next.base_sel        = byte_in[2:0];
          rec_next.base_valid      = sea_w.base_valid;
          rec_next.base_reg        = sea_w.base_reg;
          rec_next.index_valid     = sea_w.index_valid;
          rec_next.index_reg       = sea_w.index_reg;
          rec_next.stack_segment   = sea_w.stack;
          rec_next.ea_undefined    = !sea_w.index_valid && (byte_in[7:6] != 2'h0);
          rec_next.disp_len        = sdisp_w;
          state_next = (sdisp_w != LEN_NONE) ? ST_DISP : imm_or_emit;
        end
      end
      // Displacement bytes, least significant first
      ST_DISP: begin
        if (take) begin
          rec_next.disp[{cnt_reg, 3'h0} +: 8] = byte_in;
          if (disp_last) begin
            cnt_next   = CNT_RESET;
            state_next = imm_or_emit;
          end else begin
            cnt_next = 2'(cnt_reg + 2'h1);
          end
        end
      end
      // Immediate bytes, always the final field
      ST_IMM: begin
        if (take) begin
          rec_next.imm[{cnt_reg, 3'h0} +: 8] = byte_in;
          if (imm_last) begin
            cnt_next   = CNT_RESET;
            state_next = ST_EMIT;
          end else begin
            cnt_next = 2'(cnt_reg + 2'h1);
          end
        end
      end
      // Hand the record over, then forget the prefixes
      ST_EMIT: begin
        if (link.ready) begin
          rec_next   = '0;
          opp_next   = 1'b0;
          adp_next   = 1'b0;
          state_next = ST_OPCODE;
        end
      end
      default: begin
        state_next = ST_OPCODE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_OPCODE;
      rec_reg   <= '0;
      cnt_reg   <= CNT_RESET;
      opp_reg   <= 1'b0;
      adp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      rec_reg   <= rec_next;
      cnt_reg   <= cnt_next;
      opp_reg   <= opp_next;
      adp_reg   <= adp_next;
    end
  end

  // Output buffer; a stalled consumer stalls the byte intake
  decode_out_buffer #(
    .DEPTH (BUF_DEPTH)
  ) u_out_buffer (
    .sys_clk_in    (sys_clk_in),
    .sys_rst_in    (sys_rst_in),
    .fill          (link.dst),
    .out_valid_out (done_out),
    .out_data_out  (decode_out),
    .out_ready_in  (done_ready_in)
  );

endmodule

// [prefix_and_address_mode_decoder_props.sv]
`timescale 1ns/1ps
// Watches handshakes and the head record of the decoder
module prefix_and_address_mode_decoder_props (
  // Clock and reset
  input wire logic                 sys_clk_in,
  input wire logic                 sys_rst_in,
  // Observed ports
  input wire logic                 byte_ready_out,
  input wire logic                 done_out,
  input decode_pkg::decode_rec_type decode_out,
  input wire logic                 done_ready_in
);
  import decode_pkg::*;
  decode_rec_type d;  // Short name for the head record
  assign d = decode_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_head_holds: assert property (
    done_out && !done_ready_in |=> done_out && $stable(decode_out))
    else $error("head record changed before it was taken");
  a_emit_fills: assert property (
    !byte_ready_out |=> done_out)
    else $error("record missing after an intake pause");
  a_rise_after_emit: assert property (
    $rose(done_out) |-> !$past(byte_ready_out))
    else $error("record appeared without an intake pause");
  a_opcode_bits: assert property (
    done_out |-> d.byte_or_full_flag == d.opcode[W_BIT] && d.flow_way_bit == d.opcode[D_BIT]
      && d.imm_extend_flag == d.opcode[S_BIT])
    else $error("single-bit opcode fields wrong");
  a_small_fields: assert property (
    done_out |-> {d.condition_code, d.segment_pick_short, d.segment_pick_long}
      == {d.opcode[3:0], d.opcode[4:3], d.opcode[5:3]})
    else $error("condition or segment field wrong");
  a_reg_form: assert property (
    done_out && d.has_modrm |-> d.reg_operand == (d.mod == MOD_REG))
    else $error("register form flag wrong");
  a_sib_gate: assert property (
    done_out && d.has_sib |-> d.addr32 && d.mod != MOD_REG && d.rm == RM_SIB)
    else $error("scale-index byte taken where not allowed");
  a_undef_ea: assert property (
    done_out && d.has_sib |-> d.ea_undefined
      == (d.index_sel == INDEX_NONE && d.multiplier_code != 2'h0))
    else $error("undefined address flag wrong");
endmodule
bind prefix_and_address_mode_decoder prefix_and_address_mode_decoder_props u_props (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .byte_ready_out(byte_ready_out),
  .done_out(done_out), .decode_out(decode_out), .done_ready_in(done_ready_in));

// [fetch_byte_model.sv]
`timescale 1ns/1ps
// Fetch side: queued bytes in order, random gaps between them
module fetch_byte_model (
  // Clock and reset
  input  wire logic                sys_clk_in,
  input  wire logic                sys_rst_in,
  // Byte stream toward the decoder
  input  wire logic                ready_in,
  output logic [7:0]               byte_out,
  output logic                     valid_out,
  output logic                     modrm_out,
  output decode_pkg::imm_kind_type kind_out
);
  import decode_pkg::*;
  logic [10:0] q[$];       // Pending {modrm, kind, byte}
  int          stall_pct;  // Gap chance in percent
  logic        take;       // Byte accepted at this edge
  initial begin
    stall_pct = 0;
    byte_out = 8'h00;
    valid_out = 1'b0;
    modrm_out = 1'b0;
    kind_out = IMM_NONE;
  end
  // Hold a byte until taken; in a gap the bus toggles so stale data never looks valid
  always @(posedge sys_clk_in) begin
    take = valid_out && ready_in && !sys_rst_in;
    if (take) void'(q.pop_front());
    if (sys_rst_in) valid_out <= 1'b0;
    else if (take || !valid_out) begin
      if (q.size() > 0 && $urandom_range(99) >= stall_pct) begin
        valid_out <= 1'b1;
        byte_out  <= q[0][7:0];
        modrm_out <= q[0][10];
        kind_out  <= imm_kind_type'(q[0][9:8]);
      end else begin
        valid_out <= 1'b0;
        byte_out  <= ~byte_out;
      end
    end
  end
endmodule

// [prefix_and_address_mode_decoder_tb.sv]
`timescale 1ns/1ps
// Random instructions in all width modes, with stalls on both sides
module prefix_and_address_mode_decoder_tb;
  import decode_pkg::*;
  logic           sys_clk_in, sys_rst_in, done_ready_in;
  logic           op32_def, addr32_def, compat;  // Mode inputs
  logic           hold_rdy;                       // Consumer stalls while set
  logic [7:0]     byte_w;
  logic           valid_w, modrm_w, byte_ready_out, done_out;
  imm_kind_type   kind_w;
  decode_rec_type decode_out;
  logic [127:0]   exp_q[$];                       // Expected records in order
  int             miscompares, tests_run, cycles;
  prefix_and_address_mode_decoder u_prefix_and_address_mode_decoder (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .default_op32_in(op32_def),
    .default_addr32_in(addr32_def), .compat_mode_in(compat), .byte_in(byte_w),
    .byte_valid_in(valid_w), .has_modrm_in(modrm_w), .imm_kind_in(kind_w),
    .byte_ready_out(byte_ready_out), .done_out(done_out), .decode_out(decode_out),
    .done_ready_in(done_ready_in));
  fetch_byte_model u_fetch_byte_model (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .ready_in(byte_ready_out), .byte_out(byte_w), .valid_out(valid_w),
    .modrm_out(modrm_w), .kind_out(kind_w));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic mr, input logic [1:0] k);
    u_fetch_byte_model.q.push_back({mr, k, b});
  endtask
  // Least significant byte first
  task automatic put_n(input logic [31:0] v, input logic [2:0] n);
    for (int i = 0; i < n; i++) put(v[8*i +: 8], 1'b0, 2'h0);
  endtask
  // Builds one instruction and its expected record
  task automatic gen_instr();
    logic       p66, p67, two, mr, o32, a32, sib, stk;
    logic [7:0] op, m, s;
    logic [1:0] k, md;
    logic [2:0] dl, il;
    logic [31:0] dv, iv;
    logic [3:0] bx16, ix16;
    logic [7:0] ea;
    {p66, p67, two, mr} = 4'($urandom_range(15));
    k = 2'($urandom_range(3));
    op = 8'($urandom);
    m = 8'($urandom);
    s = 8'($urandom);
    md = m[7:6];
    if (p66) put(PFX_OP_SIZE, 1'b0, 2'h0);
    if (p67) put(PFX_ADDR_SIZE, 1'b0, 2'h0);
    if (p67) put(PFX_ADDR_SIZE, 1'b0, 2'h0);  // A repeat must not toggle back
    if (two) put(ESC_TWO_BYTE, 1'b0, 2'h0);
    else if (op inside {PFX_OP_SIZE, PFX_ADDR_SIZE, ESC_TWO_BYTE}) op ^= 8'h80;
    put(op, mr, k);
    o32 = (op32_def & !compat) ^ p66;
    a32 = (addr32_def & !compat) ^ p67;
    sib = mr && a32 && md != MOD_REG && m[2:0] == RM_SIB;
    dl = !mr || md == MOD_REG ? LEN_NONE : md == MOD_DISP8 ? LEN_BYTE
       : md == MOD_DISPW ? (a32 ? LEN_DWORD : LEN_WORD)
       : !a32 && m[2:0] == RM16_DIRECT ? LEN_WORD
       : a32 && (m[2:0] == RM32_DIRECT || sib && s[2:0] == BASE_DIRECT) ? LEN_DWORD : LEN_NONE;
    stk = mr && md != MOD_REG && (a32 ? (sib ? s[2:0] == REG_SP
       || s[2:0] == REG_BP && md != MOD_NO_DISP : md == MOD_DISP8 && m[2:0] == REG_BP)
       : md != MOD_DISPW && (m[2:0] inside {3'h2, 3'h3} || md == MOD_DISP8 && m[2:0] == 3'h6));
    il = k == IMM_BYTE ? LEN_BYTE : k == IMM_FULL || k == IMM_VAR && op[0]
       ? (o32 ? LEN_DWORD : LEN_WORD) : k == IMM_VAR ? LEN_BYTE : LEN_NONE;
    dv = $urandom & (32'hffff_ffff >> (32 - 8 * dl));
    iv = $urandom & (32'hffff_ffff >> (32 - 8 * il));
    if (mr) put(m, 1'b0, 2'h0);
    if (sib) put(s, 1'b0, 2'h0);
    put_n(dv, dl);
    put_n(iv, il);
    // Address registers from the tables; a register not used reads as zero
    bx16 = m[2:0] inside {3'h2, 3'h3} || m[2:0] == 3'h6 && md != MOD_NO_DISP ? {1'b1, REG_BP}
         : m[2:0] inside {3'h0, 3'h1, 3'h7} ? {1'b1, REG_BX} : 4'h0;
    ix16 = m[2:0] > 3'h5 ? 4'h0 : {1'b1, m[0] ? REG_DI : REG_SI};
    ea = !mr || md == MOD_REG ? 8'h0 : !a32 ? {bx16, ix16}
       : sib ? {s[2:0] != BASE_DIRECT || md != MOD_NO_DISP, s[2:0], s[5:3] != INDEX_NONE, s[5:3]}
       : {md != MOD_NO_DISP || m[2:0] != RM32_DIRECT, m[2:0], 4'h0};
    ea &= {1'b1, {3{ea[7]}}, 1'b1, {3{ea[3]}}};
    exp_q.push_back({o32, a32, two, op, sib, stk,
      sib && s[5:3] == INDEX_NONE && s[7:6] != 2'h0, dl, dv, il, iv,
      mr, mr ? m : 8'h0, mr && md == MOD_REG, sib ? s : 8'h0, ea});
  endtask
  task automatic drain();
    while (exp_q.size() > 0) @(posedge sys_clk_in);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Consumer with random stalls, watchdog
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
    done_ready_in <= !hold_rdy && $urandom_range(1);
    if (!sys_rst_in && done_out === 1'b1 && done_ready_in === 1'b1) begin
      check({decode_out.op32, decode_out.addr32, decode_out.two_byte, decode_out.opcode,
        decode_out.has_sib, decode_out.stack_segment, decode_out.ea_undefined,
        decode_out.disp_len, decode_out.disp, decode_out.imm_len, decode_out.imm,
        decode_out.has_modrm, decode_out.mod, decode_out.operand_slot, decode_out.rm,
        decode_out.reg_operand, decode_out.multiplier_code, decode_out.index_sel,
        decode_out.base_sel, decode_out.base_valid,
        decode_out.base_reg & {3{decode_out.base_valid}}, decode_out.index_valid,
        decode_out.index_reg & {3{decode_out.index_valid}}},
        exp_q.pop_front());
    end
  end
  initial begin
    {sys_rst_in, done_ready_in, op32_def, addr32_def, compat, hold_rdy} = 6'h20;
    {miscompares, tests_run, cycles} = '0;
    void'($urandom(84332));
    repeat (16) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    for (int m = 0; m < 5; m++) begin
      @(posedge sys_clk_in);
      op32_def <= m[0] | m[2];
      addr32_def <= m[1] | m[2];
      compat <= m == 4;
      u_fetch_byte_model.stall_pct = m * 20;
      @(posedge sys_clk_in);
      repeat (40) gen_instr();
      drain();
      $display("mode test %0d done", m);
    end
    hold_rdy <= 1'b1;
    // No fetch gaps, so the buffer is surely full before the intake is looked at
    u_fetch_byte_model.stall_pct = 0;
    repeat (4) gen_instr();
    repeat (100) @(posedge sys_clk_in);
    check(byte_ready_out, 1'b0);
    check(done_out, 1'b1);
    hold_rdy <= 1'b0;
    drain();
    $display("back-pressure test done");
    give_verdict();
  end
endmodule
